// *** dv/oscr_ref_sink.sv ***
// Purpose: external load on the reference clock pin
// Assumes: the load samples the pin on the system clock
// Notes: period drops to 0 once the pin has been still for long
`timescale 1ns/1ns
module oscr_ref_sink (
    input wire logic clock,
    input wire logic refclk_pin,
    output int period
);
    logic last_q = 1'b0; // pin level at the previous edge
    int cnt_q = 0; // cycles since the last rising edge
    // measure the spacing of rising edges on the pin
    always @(posedge clock) begin
        last_q <= refclk_pin;
        if (refclk_pin === 1'b1 && last_q === 1'b0) begin
            period <= cnt_q;
            cnt_q <= 1;
        end else begin
            cnt_q <= cnt_q + 1;
            // a stopped clock reads as no period at all
            if (cnt_q > 600) period <= 0;
        end
    end
endmodule : oscr_ref_sink

// *** dv/tb.sv ***
// Purpose: self-checking bench for the oscillator switch block
// Assumes: apb master tasks, one 20 mhz clock
// Notes: integer model of the control register gives expectations
`timescale 1ns/1ns
module tb;
    logic clock = 1'b0; // system clock
    logic resetn = 1'b0; // active low reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat; // rdat: last read
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, rerr, a;
    logic [7:0] src_ready = 8'h00; // per-source ready flags
    logic pll_lock = 1'b0, xtal_in_pin = 1'b0, sleep_mode = 1'b0;
    logic [1:0] prim_mode = 2'h0; // starts in external clock mode
    logic [2:0] cur_source, xcnt = 3'h0;
    logic clock_out_pin, clock_out_oe, refclk_pin, refclk_pin_oe, pdown;
    int period, code, n, error_cnt = 0, comparisons = 0, seed = 32'h4e3c;
    int m_new = 0, m_cur = 0, m_swen = 0, m_lock = 0; // model state
    always #25 clock = ~clock;
    // crystal pin toggles every three clocks, six-cycle period
    always @(posedge clock) begin
        xcnt <= (xcnt == 3'h2) ? 3'h0 : xcnt + 3'h1;
        if (xcnt == 3'h2) xtal_in_pin <= ~xtal_in_pin;
    end
    oscr_top dut (.clock(clock), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_ready(src_ready), .pll_lock(pll_lock),
        .xtal_in_pin(xtal_in_pin), .prim_mode(prim_mode),
        .sleep_mode(sleep_mode), .cur_source(cur_source),
        .clock_out_pin(clock_out_pin), .clock_out_oe(clock_out_oe),
        .refclk_pin(refclk_pin), .refclk_pin_oe(refclk_pin_oe),
        .primary_powerdown(pdown));
    oscr_ref_sink sink (.clock(clock), .refclk_pin(refclk_pin),
        .period(period));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] ad,
        input logic [31:0] d, input logic [3:0] s);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        // answer taken at the very edge that samples pready high
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never re-raises psel at once
        @(posedge clock);
    endtask : apb
    // write to the oscillator control register
    task automatic w0(input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, 12'h000, d, s);
    endtask : w0
    // read oscillator control and compare with the model
    task automatic rd_osc();
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        chk(rdat, 32'(m_cur << 12 | m_new << 8 | m_lock << 5 | m_swen));
    endtask : rd_osc
    // unlock the high byte and choose a source, nothing between
    task automatic set_src(input int src);
        w0(32'h0000_7800, 4'h2);
        w0(32'h0000_9a00, 4'h2);
        w0(32'(src << 8), 4'h2);
        m_new = src;
    endtask : set_src
    // unlock the low byte and request the switch
    task automatic go();
        w0(32'h0000_0046, 4'h1);
        w0(32'h0000_0057, 4'h1);
        w0(32'h0000_0001, 4'h1);
        m_swen = 1;
    endtask : go
    // software delay loop: poll until the enable bit clears
    task automatic poll();
        n = 0;
        do begin
            apb(1'b0, 12'h000, 32'h0, 4'h0);
            n++;
        end while (rdat[0] !== 1'b0 && n < 20);
    endtask : poll
    // clock out: 3 when it toggles and is driven, 0 when held off
    task automatic ck_out(input logic [31:0] exp);
        @(negedge clock);
        a = clock_out_pin;
        @(negedge clock);
        chk({30'h0, clock_out_oe, clock_out_pin !== a}, exp);
        // hand back on a rising edge so stimulus stays edge aligned
        @(posedge clock);
    endtask : ck_out
    // set the reference control word and let it settle
    task automatic ref_set(input logic [31:0] d, input int wait_cy);
        apb(1'b1, 12'h004, d, 4'h2);
        repeat (wait_cy) @(posedge clock);
    endtask : ref_set
    // print counts and the verdict, then stop
    task automatic tally_and_finish();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    // cut a hang short
    initial begin
        #(50 * 20000);
        error_cnt++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        rd_osc();
        apb(1'b0, 12'h008, 32'h0, 4'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdat, 32'h0);
        // protected writes without a prior unlock are dropped
        w0(32'h0000_0300, 4'h2);
        w0(32'h0000_0001, 4'h1);
        rd_osc();
        // stray writes break the unlock
        code = $random(seed) & 32'hff;
        if (code == 32'h9a) code = 0;
        w0(32'h0000_7800, 4'h2);
        w0(32'(code << 8), 4'h2);
        w0(32'h0000_9a00, 4'h2);
        w0(32'h0000_0300, 4'h2);
        w0(32'h0000_7800, 4'h2);
        w0(32'h0000_9a00, 4'h2);
        w0(32'h0000_0046, 4'h1);
        w0(32'h0000_0300, 4'h2);
        rd_osc();
        // successful switch to the primary source
        src_ready <= 8'(($random(seed) & 32'hf0) | 32'h04);
        set_src(2);
        rd_osc();
        go();
        poll();
        m_cur = 2;
        m_swen = 0;
        rd_osc();
        chk({29'h0, cur_source}, 32'h2);
        ck_out(32'h3);
        prim_mode <= 2'h1;
        repeat (3) @(posedge clock);
        ck_out(32'h0);
        // pll source without lock: switch stays pending
        src_ready <= src_ready | 8'h02;
        set_src(1);
        go();
        repeat (10) @(posedge clock);
        rd_osc();
        pll_lock <= 1'b1;
        m_lock = 1;
        poll();
        m_cur = 1;
        m_swen = 0;
        rd_osc();
        ck_out(32'h3);
        // reference divider on the system clock, random ratios
        repeat (4) begin
            code = $random(seed) & 7;
            ref_set(32'(32'h8000 | code << 8), 4 * (2 << code) + 12);
            chk(period, 2 << code);
            chk({31'h0, refclk_pin_oe}, 32'h1);
            apb(1'b0, 12'h004, 32'h0, 4'h0);
            chk(rdat, 32'(32'h8000 | code << 8));
        end
        // reference taken from the crystal pin
        ref_set(32'h0000_9000, 80);
        chk(period, 12);
        // sleep without sleep-run stops the output
        sleep_mode <= 1'b1;
        repeat (700) @(posedge clock);
        chk(period, 0);
        chk({31'h0, pdown}, 32'h1);
        // sleep-run and crystal select keep it going
        ref_set(32'h0000_b000, 80);
        chk(period, 12);
        chk({31'h0, pdown}, 32'h0);
        prim_mode <= 2'h3;
        repeat (4) @(posedge clock);
        chk({31'h0, pdown}, 32'h1);
        sleep_mode <= 1'b0;
        // clearing the enable withholds the clock
        ref_set(32'h0000_0000, 700);
        chk(period, 0);
        chk({31'h0, refclk_pin_oe}, 32'h0);
        tally_and_finish();
    end
endmodule : tb

// *** rtl/oscr_div_if.sv ***
// Purpose: link between control logic and reference divider
// Assumes: same clock on both sides
// Notes: tick marks one source edge
`timescale 1ns/1ns
interface oscr_div_if;
    logic tick; // one source edge this cycle
    logic run; // divider may run
    logic [3:0] code; // divide select
    logic refclk; // divided clock, from a flop
    modport ctrl(output tick, output run, output code, input refclk);
    modport div(input tick, input run, input code, output refclk);
endinterface : oscr_div_if

// *** rtl/oscr_pkg.sv ***
// Purpose: constants and types of the oscillator switch block
// Assumes: apb4 slave, 32-bit data, one clock at 20 mhz
// Notes: offsets are byte addresses
package oscr_pkg;
    // register byte offsets
    localparam logic [11:0] OSC_CTRL_OFS = 12'h000;
    localparam logic [11:0] REFCLK_CTRL_OFS = 12'h004;
    // unlock keys
    localparam logic [7:0] KEY_HI_1 = 8'h78;
    localparam logic [7:0] KEY_HI_2 = 8'h9a;
    localparam logic [7:0] KEY_LO_1 = 8'h46;
    localparam logic [7:0] KEY_LO_2 = 8'h57;
    // byte strobes of a single byte write
    localparam logic [3:0] STRB_HI = 4'h2;
    localparam logic [3:0] STRB_LO = 4'h1;
    // oscillator control fields
    localparam int SWEN_BIT = 0;
    localparam int LOCK_BIT = 5;
    localparam int NOSC_LSB = 8;
    localparam int COSC_LSB = 12;
    localparam int SRC_W = 3;
    // reference clock control fields
    localparam int REF_EN_BIT = 15;
    localparam int REF_SLP_BIT = 13;
    localparam int REF_SEL_BIT = 12;
    localparam int REF_DIV_LSB = 8;
    localparam int REF_DIV_W = 4;
    localparam int DIV_CNT_W = 15;
    // oscillator source codes
    localparam logic [2:0] SRC_FRC = 3'h0;
    localparam logic [2:0] SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_RESET = 3'h0;
    // primary oscillator configuration
    localparam logic [1:0] PM_EC = 2'h0;
    localparam logic [1:0] PM_XT = 2'h1;
    localparam logic [1:0] PM_HS = 2'h2;
    localparam logic [1:0] PM_OFF = 2'h3;
    // unlock sequence states
    typedef enum logic [2:0] {
        LK_IDLE = 3'b001,
        LK_KEY1 = 3'b010,
        LK_OPEN = 3'b100
    } oscr_lock_e;
    // true when a source code runs through the pll
    function automatic logic uses_pll(input logic [2:0] src);
        uses_pll = (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
    endfunction : uses_pll
    // true when a source code runs on the primary pins
    function automatic logic uses_pri(input logic [2:0] src);
        uses_pri = (src == SRC_PRI) || (src == SRC_PRI_PLL);
    endfunction : uses_pri
endpackage : oscr_pkg

// *** rtl/oscr_refdiv.sv ***
// Purpose: reference clock divider
// Assumes: tick is one cycle wide per source edge
// Notes: half period is 2**code ticks
`timescale 1ns/1ns
module oscr_refdiv (
    input wire logic clock,
    input wire logic resetn,
    oscr_div_if.div d
);
    logic [oscr_pkg::DIV_CNT_W-1:0] cnt_q; // ticks in this half
    logic out_q; // divided output

    // last count of a half period for a code
    function automatic logic [oscr_pkg::DIV_CNT_W-1:0] lim(
        input logic [3:0] code);
        logic [oscr_pkg::DIV_CNT_W:0] one;
        one = 16'h0001;
        lim = oscr_pkg::DIV_CNT_W'((one << code) - 16'h0001);
    endfunction : lim

    // count ticks and toggle at the end of each half period
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end else if (!d.run) begin // stopped: park low
            cnt_q <= '0;
            out_q <= 1'b0;
        end else if (d.tick) begin
            if (cnt_q >= lim(d.code)) begin
                cnt_q <= '0;
                out_q <= ~out_q;
            end else begin
                cnt_q <= cnt_q + 15'h0001;
            end
        end
    end

    assign d.refclk = out_q;

    chk_div_parked: assert property (@(posedge clock)
        disable iff (!resetn) !d.run |=> !out_q)
        else $error("reference clock not parked when stopped");
    chk_div_tick: assert property (@(posedge clock)
        disable iff (!resetn) d.run && !d.tick |=> $stable(out_q))
        else $error("reference clock moved without a tick");
    chk_div_code0: assert property (@(posedge clock)
        disable iff (!resetn)
        d.run && d.tick && d.code == 4'h0 && cnt_q == 15'h0
        |=> out_q != $past(out_q))
        else $error("divide code 0 did not toggle each tick");
endmodule : oscr_refdiv

// *** rtl/oscr_top.sv ***
// Purpose: oscillator switch unlock and reference clock out
// Assumes: apb4 master, pins and analog flags asynchronous
// Notes: each oscillator control write counts as one instruction
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module oscr_top (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] src_ready,
    input wire logic pll_lock,
    input wire logic xtal_in_pin,
    input wire logic [1:0] prim_mode,
    input wire logic sleep_mode,
    output logic [2:0] cur_source,
    output logic clock_out_pin,
    output logic clock_out_oe,
    output logic refclk_pin,
    output logic refclk_pin_oe,
    output logic primary_powerdown
);
    // apb handshake state
    logic pready_q; // second access cycle
    logic pslverr_q; // unmapped address
    logic [31:0] prdata_q; // read data
    logic apb_acc; // access phase
    logic apb_wr; // write takes effect now
    logic mapped; // address hits a register
    // oscillator control state
    oscr_pkg::oscr_lock_e hi_st_q; // high byte unlock
    oscr_pkg::oscr_lock_e lo_st_q; // low byte unlock
    logic [2:0] new_src_q; // requested source
    logic [2:0] cur_src_q; // running source
    logic swen_q; // switch in progress
    // reference clock control state
    logic ref_en_q; // output enable
    logic ref_slp_q; // keep running in sleep
    logic ref_sel_q; // 1 primary pins, 0 system
    logic [3:0] ref_div_q; // divide select
    // synchronisers
    logic [7:0] rdy_m_q, rdy_s_q; // source ready
    logic lock_m_q, lock_s_q; // pll lock
    logic xtal_m_q, xtal_s_q, xtal_d_q; // primary pin
    // pin drivers
    logic clock_out_pin_q, clock_out_pin_oe_q, ref_oe_q, pd_q;
    // decode
    logic wr_osc, hi_only, lo_only, hi_take, lo_take;
    logic target_ok, clock_out_pin_ok, keep_sleep;

    oscr_div_if div_bus ();

    // next unlock state for one byte of the control word
    function automatic oscr_pkg::oscr_lock_e lock_next(
        input oscr_pkg::oscr_lock_e st,
        input logic mine,
        input logic [7:0] data,
        input logic [7:0] k1,
        input logic [7:0] k2);
        lock_next = oscr_pkg::LK_IDLE;
        if (mine) begin
            case (st)
                oscr_pkg::LK_IDLE: begin
                    if (data == k1) begin
                        lock_next = oscr_pkg::LK_KEY1;
                    end
                end
                oscr_pkg::LK_KEY1: begin
                    if (data == k2) begin
                        lock_next = oscr_pkg::LK_OPEN;
                    end
                end
                default: begin // open is used once
                    lock_next = oscr_pkg::LK_IDLE;
                end
            endcase
        end
    endfunction : lock_next

    // bus decode: writes land on the edge that sees pready
    assign apb_acc = psel && penable;
    assign apb_wr = apb_acc && pready_q && pwrite;
    assign mapped = (paddr == oscr_pkg::OSC_CTRL_OFS) ||
                    (paddr == oscr_pkg::REFCLK_CTRL_OFS);
    assign wr_osc = apb_wr && (paddr == oscr_pkg::OSC_CTRL_OFS);
    assign hi_only = (pstrb == oscr_pkg::STRB_HI);
    assign lo_only = (pstrb == oscr_pkg::STRB_LO);
    // protected writes right after a completed key pair
    assign hi_take = wr_osc && hi_only &&
                     (hi_st_q == oscr_pkg::LK_OPEN);
    assign lo_take = wr_osc && lo_only &&
                     (lo_st_q == oscr_pkg::LK_OPEN);

    // pready one cycle late so it comes from a flop
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= apb_acc && !pready_q;
            pslverr_q <= apb_acc && !pready_q && !mapped;
        end
    end

    // read mux, captured with pready
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (apb_acc && !pready_q) begin
            prdata_q <= 32'h0000_0000; // unmapped and spare bits
            if (!pwrite && paddr == oscr_pkg::OSC_CTRL_OFS) begin
                prdata_q[oscr_pkg::SWEN_BIT] <= swen_q;
                prdata_q[oscr_pkg::LOCK_BIT] <= lock_s_q;
                prdata_q[oscr_pkg::NOSC_LSB +: 3] <= new_src_q;
                prdata_q[oscr_pkg::COSC_LSB +: 3] <= cur_src_q;
            end else if (!pwrite &&
                         paddr == oscr_pkg::REFCLK_CTRL_OFS) begin
                prdata_q[oscr_pkg::REF_EN_BIT] <= ref_en_q;
                prdata_q[oscr_pkg::REF_SLP_BIT] <= ref_slp_q;
                prdata_q[oscr_pkg::REF_SEL_BIT] <= ref_sel_q;
                prdata_q[oscr_pkg::REF_DIV_LSB +: 4] <= ref_div_q;
            end
        end
    end

    // high byte unlock; any other control write resets it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hi_st_q <= oscr_pkg::LK_IDLE;
        end else if (wr_osc) begin
            hi_st_q <= lock_next(hi_st_q, hi_only, pwdata[15:8],
                                 oscr_pkg::KEY_HI_1,
                                 oscr_pkg::KEY_HI_2);
        end
    end

    // low byte unlock; any other control write resets it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lo_st_q <= oscr_pkg::LK_IDLE;
        end else if (wr_osc) begin
            lo_st_q <= lock_next(lo_st_q, lo_only, pwdata[7:0],
                                 oscr_pkg::KEY_LO_1,
                                 oscr_pkg::KEY_LO_2);
        end
    end

    // new source only from the write after the high keys
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            new_src_q <= oscr_pkg::SRC_RESET;
        end else if (hi_take) begin
            new_src_q <= pwdata[oscr_pkg::NOSC_LSB +: 3];
        end
    end

    // target is up when its ready flag, and pll lock if used
    assign target_ok = rdy_s_q[new_src_q] &&
        (!oscr_pkg::uses_pll(new_src_q) || lock_s_q);

    // switch enable: software write wins over hardware clear
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            swen_q <= 1'b0;
        end else if (lo_take) begin
            swen_q <= pwdata[oscr_pkg::SWEN_BIT];
        end else if (swen_q && target_ok) begin
            swen_q <= 1'b0;
        end
    end

    // running source follows a completed switch
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cur_src_q <= oscr_pkg::SRC_RESET;
        end else if (swen_q && target_ok) begin
            cur_src_q <= new_src_q;
        end
    end

    // reference control register, high byte lane only
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ref_en_q <= 1'b0;
            ref_slp_q <= 1'b0;
            ref_sel_q <= 1'b0;
            ref_div_q <= 4'h0;
        end else if (apb_wr && pstrb[1] &&
                     paddr == oscr_pkg::REFCLK_CTRL_OFS) begin
            ref_en_q <= pwdata[oscr_pkg::REF_EN_BIT];
            ref_slp_q <= pwdata[oscr_pkg::REF_SLP_BIT];
            ref_sel_q <= pwdata[oscr_pkg::REF_SEL_BIT];
            ref_div_q <= pwdata[oscr_pkg::REF_DIV_LSB +: 4];
        end
    end

    // two-flop synchronisers for asynchronous inputs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdy_m_q <= 8'h00;
            rdy_s_q <= 8'h00;
            lock_m_q <= 1'b0;
            lock_s_q <= 1'b0;
            xtal_m_q <= 1'b0;
            xtal_s_q <= 1'b0;
            xtal_d_q <= 1'b0;
        end else begin
            rdy_m_q <= src_ready;
            rdy_s_q <= rdy_m_q;
            lock_m_q <= pll_lock;
            lock_s_q <= lock_m_q;
            xtal_m_q <= xtal_in_pin;
            xtal_s_q <= xtal_m_q;
            xtal_d_q <= xtal_s_q;
        end
    end

    // clock out only where the crystal does not own the pins
    assign clock_out_pin_ok = !(oscr_pkg::uses_pri(cur_src_q) &&
        (prim_mode == oscr_pkg::PM_XT ||
         prim_mode == oscr_pkg::PM_HS));
    // sleep keeps the output only with both bits and primary on
    assign keep_sleep = ref_slp_q && ref_sel_q &&
                        (prim_mode != oscr_pkg::PM_OFF);

    // fosc/2 toggle and pin drivers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            clock_out_pin_q <= 1'b0;
            clock_out_pin_oe_q <= 1'b0;
            ref_oe_q <= 1'b0;
            pd_q <= 1'b0;
        end else begin
            clock_out_pin_q <= clock_out_pin_ok ? ~clock_out_pin_q : 1'b0;
            clock_out_pin_oe_q <= clock_out_pin_ok;
            ref_oe_q <= ref_en_q;
            pd_q <= sleep_mode && !keep_sleep;
        end
    end

    // divider source: primary pin edges or every system cycle
    assign div_bus.tick = ref_sel_q ? (xtal_s_q && !xtal_d_q)
                                    : 1'b1;
    assign div_bus.run = ref_en_q &&
        (!sleep_mode || keep_sleep);
    assign div_bus.code = ref_div_q;

    oscr_refdiv u_refdiv (
        .clock(clock),
        .resetn(resetn),
        .d(div_bus.div)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cur_source = cur_src_q;
    assign clock_out_pin = clock_out_pin_q;
    assign clock_out_oe = clock_out_pin_oe_q;
    assign refclk_pin = div_bus.refclk;
    assign refclk_pin_oe = ref_oe_q;
    assign primary_powerdown = pd_q;

    chk_hi_open_path: assert property (@(posedge clock)
        disable iff (!resetn) $rose(hi_st_q == oscr_pkg::LK_OPEN)
        |-> $past(hi_st_q) == oscr_pkg::LK_KEY1 &&
            $past(pwdata[15:8]) == oscr_pkg::KEY_HI_2)
        else $error("high byte opened without second key");
    chk_nosc_guard: assert property (@(posedge clock)
        disable iff (!resetn) $changed(new_src_q)
        |-> $past(hi_st_q) == oscr_pkg::LK_OPEN && $past(wr_osc))
        else $error("new source changed outside unlock window");
    chk_lo_open_path: assert property (@(posedge clock)
        disable iff (!resetn) $rose(lo_st_q == oscr_pkg::LK_OPEN)
        |-> $past(lo_st_q) == oscr_pkg::LK_KEY1 &&
            $past(pwdata[7:0]) == oscr_pkg::KEY_LO_2)
        else $error("low byte opened without second key");
    chk_swen_start: assert property (@(posedge clock)
        disable iff (!resetn) $rose(swen_q)
        |-> $past(lo_st_q) == oscr_pkg::LK_OPEN)
        else $error("switch started without low unlock");
    chk_swen_done: assert property (@(posedge clock)
        disable iff (!resetn) swen_q && target_ok && !lo_take
        |=> !swen_q && cur_src_q == $past(new_src_q))
        else $error("switch did not complete and clear");
    chk_stray_abort: assert property (@(posedge clock)
        disable iff (!resetn) wr_osc && !hi_only
        |=> hi_st_q == oscr_pkg::LK_IDLE)
        else $error("stray control write left unlock armed");
    chk_clock_out_pin_rate: assert property (@(posedge clock)
        disable iff (!resetn) clock_out_pin_ok [*3]
        |-> clock_out_pin_q != $past(clock_out_pin_q) && clock_out_pin_oe_q)
        else $error("clock out is not half the clock");
    chk_sleep_pd: assert property (@(posedge clock)
        disable iff (!resetn) sleep_mode && !keep_sleep
        |=> pd_q && !refclk_pin)
        else $error("sleep did not stop primary and output");
endmodule : oscr_top
